// ==== hdl/switch_config_register_bank.sv ====
// Purpose: Configuration register bank of a six-channel protected high-side switch.
// Assumes: frameValid pulses once per completed command byte from the serial front end.
// Notes:   Write-only clear and reset bits leave one-cycle pulses and are never stored.
// Operation
// - Write frame bit 6 picks bank zero (output/restart status) or bank one.
// - Output control bits 5:0 reset off, set turns the channel on.
// - Read-only 3-bit restart count of the multiplexer-selected channel, reset zero.
// - Read-only slew-rate bits per channel; zero normal, one adjusted.
// - Overcurrent bits 3:1 pick high threshold at zero, low at one.
// - Restart strategy bits 3:1 pick auto restart at zero, latch at one.
// - Sense range bits 3:1 pick high ratio range at zero, low at one.
// - Write-only bit 0 sets slew rate of multiplexer-selected channel.
// - Writing one to bit 1 clears selected channel counter and latch.
// - Parallel bit 3 makes outputs 1 and 2 a parallel pair.
// - Writing one to clear bit 0 clears every channel counter and latch.
// - Hardware configuration bit 1 reads one while multiplexer holds sleep code.
// - Combine bit 2 picks OR at zero and AND at one for inputs.
// - Limp-home high forces OR combination regardless of the combine bit.
// - Master writes a four-bit checksum; device takes it for comparison.
// - Input/checksum read shows input pin levels in bits 3:0.
// - Selected output off leaves sense pin high-impedance; code 111 means sleep.
// - Output on routes channel 0-5 sense for codes 000-101 only.
// - Bank switch bit 3 chooses which bank-one registers accept writes.
// - Bank switch changes on writes only; reads ignore it and take command bit 3 as address.
// - Checksum compared once; fail flag clears on next diagnosis readout.
`timescale 1ns/10ps
module switch_config_register_bank (
  input  logic                   clk_sys,
  input  logic                   rst_n,
  input  logic                   frameValid,
  input  logic [7:0]             frameData,
  input  logic                   stdDiagRead,
  input  logic [3:0]             inputPin,
  input  logic                   limpHome,
  input  logic [17:0]            restartCounts,
  output logic [7:0]             respData,
  output logic                   respValid,
  output logic [5:0]             channelDrive,
  output logic [5:0]             faultClear,
  output logic                   softReset,
  output logic                   checksumFail,
  output switch_cfg_pkg::cfg_t   cfgOut,
  output switch_cfg_pkg::sense_t senseOut
);

  typedef enum logic [2:0] {
    CS_IDLE    = 3'b001,
    CS_COMPARE = 3'b010,
    CS_HOLD    = 3'b100
  } csum_state_t;

  switch_cfg_pkg::cfg_t   cfg;
  switch_cfg_pkg::cfg_t   next_cfg;
  switch_cfg_pkg::sense_t senseDec;
  csum_state_t            csumState;
  logic [3:0]             checksumIn;
  logic [3:0]             expected;
  logic [2:0]             restartStatus;
  logic [5:0]             driveNow;
  logic [7:0]             next_resp;
  logic                   isWrite;
  logic                   isRead;
  logic                   limpPrev;
  logic [3:0]             dataNib;
  logic [1:0]             addr0;
  logic                   bankOne;
  logic                   wrOcr;
  logic                   wrRcd;
  logic                   wrKrc;
  logic                   wrPcs;
  logic                   wrHwcr;
  logic                   wrIcs;
  logic                   wrDcr;
  logic                   wrOut;
  logic                   resetCmd;

  // Picks the bank-one register pair member that the switch bit enables.
  function automatic logic bankHit(input logic [1:0] a0, input logic [1:0] want,
                                   input logic swr, input logic wantSwr);
    bankHit = (a0 == want) && (swr == wantSwr);
  endfunction : bankHit

  // Pads a three-bit per-channel field into a response nibble with bit 0 clear.
  function automatic logic [7:0] fieldResp(input logic [3:0] hdr, input logic [3:1] f);
    fieldResp = {hdr, f, 1'b0};
  endfunction : fieldResp

  always_comb begin
    isWrite  = frameValid && frameData[switch_cfg_pkg::CMD_WRITE_BIT];
    isRead   = frameValid && !frameData[switch_cfg_pkg::CMD_WRITE_BIT];
    dataNib  = frameData[3:0];
    addr0    = frameData[switch_cfg_pkg::ADDR0_MSB:switch_cfg_pkg::ADDR0_LSB];
    bankOne  = frameData[switch_cfg_pkg::BANK_BIT];
    wrOut    = isWrite && !bankOne;
    // The switch bit only gates writes; it is never altered by a read.
    wrOcr  = isWrite && bankOne && bankHit(addr0, switch_cfg_pkg::ADDR0_OCR_RCD,
                                           cfg.bankSwitch, 1'b0);
    wrRcd  = isWrite && bankOne && bankHit(addr0, switch_cfg_pkg::ADDR0_OCR_RCD,
                                           cfg.bankSwitch, 1'b1);
    wrKrc  = isWrite && bankOne && bankHit(addr0, switch_cfg_pkg::ADDR0_KRC_PCS,
                                           cfg.bankSwitch, 1'b0);
    wrPcs  = isWrite && bankOne && bankHit(addr0, switch_cfg_pkg::ADDR0_KRC_PCS,
                                           cfg.bankSwitch, 1'b1);
    wrHwcr = isWrite && bankOne && bankHit(addr0, switch_cfg_pkg::ADDR0_HARDWARE_CONFIGURATION_ICS,
                                           cfg.bankSwitch, 1'b0);
    wrIcs  = isWrite && bankOne && bankHit(addr0, switch_cfg_pkg::ADDR0_HARDWARE_CONFIGURATION_ICS,
                                           cfg.bankSwitch, 1'b1);
    wrDcr  = isWrite && bankOne && (addr0 == switch_cfg_pkg::ADDR0_DCR);
    resetCmd = wrHwcr && dataNib[switch_cfg_pkg::SOFT_RESET_BIT];
  end

  // Configuration update. A reset command returns the bank to its defaults.
  always_comb begin
    next_cfg = cfg;
    if (resetCmd) begin
      next_cfg = switch_cfg_pkg::CFG_RESET;
    end else begin
      if (wrOut) begin
        next_cfg.outBits = frameData[5:0];
      end
      if (wrOcr) begin
        next_cfg.ocrBits = dataNib[3:1];
      end
      if (wrRcd) begin
        next_cfg.rcdBits = dataNib[3:1];
      end
      if (wrKrc) begin
        next_cfg.krcBits = dataNib[3:1];
      end
      if (wrPcs) begin
        next_cfg.parallelPair = dataNib[switch_cfg_pkg::PARALLEL_BIT];
        if (cfg.muxSel <= switch_cfg_pkg::MUX_LAST) begin
          next_cfg.slewBits[cfg.muxSel] = dataNib[switch_cfg_pkg::SLEW_SET_BIT];
        end
      end
      if (wrHwcr) begin
        next_cfg.combineAnd = dataNib[switch_cfg_pkg::COMBINE_BIT];
      end
      if (wrDcr) begin
        next_cfg.bankSwitch = dataNib[switch_cfg_pkg::SWITCH_BIT];
        next_cfg.muxSel     = dataNib[2:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg <= switch_cfg_pkg::CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfgOut <= switch_cfg_pkg::CFG_RESET;
    end else begin
      cfgOut <= next_cfg;
    end
  end

  // Fault-clear and reset commands leave single pulses and nothing stored.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      faultClear <= 6'h00;
      softReset  <= 1'b0;
    end else begin
      faultClear <= 6'h00;
      softReset  <= resetCmd;
      if (wrHwcr && dataNib[switch_cfg_pkg::ALL_CLEAR_BIT]) begin
        faultClear <= 6'h3F;
      end else if (wrPcs && dataNib[switch_cfg_pkg::SEL_CLEAR_BIT]
                   && cfg.muxSel <= switch_cfg_pkg::MUX_LAST) begin
        faultClear[cfg.muxSel] <= 1'b1;
      end
    end
  end

  // Effective channel drive from output bits and input pins.
  always_comb begin
    driveNow = cfg.outBits;
    for (int i = 0; i < switch_cfg_pkg::NUM_INPUTS; i++) begin
      if (cfg.combineAnd && !limpHome) begin
        driveNow[i] = cfg.outBits[i] & inputPin[i];
      end else begin
        driveNow[i] = cfg.outBits[i] | inputPin[i];
      end
    end
    // The paired output follows its leader so the two halves never fight.
    if (cfg.parallelPair) begin
      driveNow[2] = driveNow[1];
    end
    if (cfg.muxSel == switch_cfg_pkg::MUX_SLEEP) begin
      driveNow = 6'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      channelDrive <= 6'h00;
    end else begin
      channelDrive <= driveNow;
    end
  end

  sense_mux_decode u_sense (
    .muxSel    (cfg.muxSel),
    .channelOn (channelDrive),
    .sense     (senseDec)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      senseOut <= '{route: 6'h00, highZ: 1'b1, sleep: 1'b1};
    end else begin
      senseOut <= senseDec;
    end
  end

  // Restart count of the multiplexer-selected channel, sampled every cycle.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      restartStatus <= 3'h0;
    end else if (cfg.muxSel <= switch_cfg_pkg::MUX_LAST) begin
      restartStatus <= restartCounts[cfg.muxSel*3 +: 3];
    end else begin
      restartStatus <= 3'h0;
    end
  end

  // Read response formatting.
  always_comb begin
    next_resp = switch_cfg_pkg::RESP_NONE;
    if (frameData[2:0] == switch_cfg_pkg::RADDR_DCR) begin
      next_resp = {switch_cfg_pkg::HDR_DCR, cfg.bankSwitch, cfg.muxSel};
    end else begin
      unique case (frameData[3:0])
        switch_cfg_pkg::RADDR_OUT:
          next_resp = {switch_cfg_pkg::HDR_BANK0, cfg.outBits};
        switch_cfg_pkg::RADDR_RCS:
          next_resp = {switch_cfg_pkg::HDR_BANK0, 3'h0, restartStatus};
        switch_cfg_pkg::RADDR_SRC:
          next_resp = {switch_cfg_pkg::HDR_BANK0, cfg.slewBits};
        switch_cfg_pkg::RADDR_OCR:
          next_resp = fieldResp(switch_cfg_pkg::HDR_OCR, cfg.ocrBits);
        switch_cfg_pkg::RADDR_RCD:
          next_resp = fieldResp(switch_cfg_pkg::HDR_OCR, cfg.rcdBits);
        switch_cfg_pkg::RADDR_KRC:
          next_resp = fieldResp(switch_cfg_pkg::HDR_KRC, cfg.krcBits);
        switch_cfg_pkg::RADDR_PCS:
          next_resp = {switch_cfg_pkg::HDR_KRC, cfg.parallelPair, 3'h0};
        switch_cfg_pkg::RADDR_HARDWARE_CONFIGURATION:
          next_resp = {switch_cfg_pkg::HDR_HARDWARE_CONFIGURATION, 1'b0, cfg.combineAnd,
                       cfg.muxSel == switch_cfg_pkg::MUX_SLEEP, 1'b0};
        switch_cfg_pkg::RADDR_ICS:
          next_resp = {switch_cfg_pkg::HDR_HARDWARE_CONFIGURATION, inputPin};
        default:
          next_resp = switch_cfg_pkg::RESP_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      respData  <= switch_cfg_pkg::RESP_NONE;
      respValid <= 1'b0;
    end else begin
      respValid <= isRead;
      if (isRead) begin
        respData <= next_resp;
      end
    end
  end

  checksum_calc u_csum (
    .cfg      (cfg),
    .expected (expected)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      limpPrev <= 1'b0;
    end else begin
      limpPrev <= limpHome;
    end
  end

  // Checksum compare: one compare after each written checksum.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      checksumIn <= 4'h0;
      csumState  <= CS_IDLE;
    end else begin
      unique case (csumState)
        CS_IDLE: begin
          if (wrIcs) begin
            checksumIn <= dataNib;
            csumState  <= CS_COMPARE;
          end
        end
        CS_COMPARE: begin
          csumState <= CS_HOLD;
        end
        CS_HOLD: begin
          if (wrIcs) begin
            checksumIn <= dataNib;
            csumState  <= CS_COMPARE;
          end
        end
      endcase
    end
  end

  // The compare result wins over a readout in the same cycle so a readout never loses it.
  // Entering limp-home discards a pending result, since it would be stale.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      checksumFail <= 1'b0;
    end else if (csumState == CS_COMPARE && !(limpHome && !limpPrev)) begin
      checksumFail <= (checksumIn != expected);
    end else if (stdDiagRead || (limpHome && !limpPrev)) begin
      checksumFail <= 1'b0;
    end
  end

endmodule : switch_config_register_bank

// ==== include/switch_cfg_pkg.sv ====
// Purpose: Shared constants and types of the switch configuration register bank.
// Assumes: One command byte per frame, already deframed by the serial front end.
// Notes:   Field positions follow the command and response byte layouts.
package switch_cfg_pkg;

  localparam int NUM_CHANNELS = 6;
  localparam int NUM_INPUTS   = 4;

  // Command byte fields.
  localparam int CMD_WRITE_BIT = 7;
  localparam int BANK_BIT      = 6;
  localparam int ADDR0_MSB     = 5;
  localparam int ADDR0_LSB     = 4;

  localparam logic [1:0] ADDR0_OCR_RCD  = 2'h0;
  localparam logic [1:0] ADDR0_KRC_PCS  = 2'h1;
  localparam logic [1:0] ADDR0_HARDWARE_CONFIGURATION_ICS = 2'h2;
  localparam logic [1:0] ADDR0_DCR      = 2'h3;

  // Read addresses in the low nibble of a read command.
  localparam logic [3:0] RADDR_OUT  = 4'h0;
  localparam logic [3:0] RADDR_RCS  = 4'h8;
  localparam logic [3:0] RADDR_SRC  = 4'h9;
  localparam logic [3:0] RADDR_OCR  = 4'h4;
  localparam logic [3:0] RADDR_RCD  = 4'hC;
  localparam logic [3:0] RADDR_KRC  = 4'h5;
  localparam logic [3:0] RADDR_PCS  = 4'hD;
  localparam logic [3:0] RADDR_HARDWARE_CONFIGURATION = 4'h6;
  localparam logic [3:0] RADDR_ICS  = 4'hE;
  localparam logic [2:0] RADDR_DCR  = 3'h7;

  // Bit positions inside the data nibble.
  localparam int SLEW_SET_BIT   = 0;
  localparam int SEL_CLEAR_BIT  = 1;
  localparam int PARALLEL_BIT   = 3;
  localparam int ALL_CLEAR_BIT  = 0;
  localparam int SOFT_RESET_BIT = 1;
  localparam int COMBINE_BIT    = 2;
  localparam int SWITCH_BIT     = 3;

  // Response headers: two bits for bank zero, a nibble for the others.
  localparam logic [1:0] HDR_BANK0 = 2'h2;
  localparam logic [3:0] HDR_OCR   = 4'hC;
  localparam logic [3:0] HDR_KRC   = 4'hD;
  localparam logic [3:0] HDR_HARDWARE_CONFIGURATION  = 4'hE;
  localparam logic [3:0] HDR_DCR   = 4'hF;
  localparam logic [7:0] RESP_NONE = 8'h00;

  localparam logic [2:0] MUX_SLEEP = 3'h7;
  localparam logic [2:0] MUX_LAST  = 3'h5;

  // Column parity of the checksum matrix: 1 marks an odd-parity column.
  localparam logic [3:0] CSUM_ODD_COLS = 4'h5;

  typedef struct packed {
    logic [5:0] outBits;
    logic [3:1] ocrBits;
    logic [3:1] rcdBits;
    logic [3:1] krcBits;
    logic       parallelPair;
    logic       combineAnd;
    logic [5:0] slewBits;
    logic       bankSwitch;
    logic [2:0] muxSel;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{outBits: 6'h00, ocrBits: 3'h0, rcdBits: 3'h0,
                                 krcBits: 3'h0, parallelPair: 1'b0, combineAnd: 1'b0,
                                 slewBits: 6'h00, bankSwitch: 1'b0, muxSel: MUX_SLEEP};

  typedef struct packed {
    logic [5:0] route;
    logic       highZ;
    logic       sleep;
  } sense_t;

endpackage : switch_cfg_pkg

// ==== hdl/checksum_calc.sv ====
// Purpose: Column parity over the protected configuration bits.
// Assumes: Configuration arrives as the shared packed struct.
// Notes:   Purely combinational; the caller registers the compare result.
`timescale 1ns/10ps
module checksum_calc (
  input  switch_cfg_pkg::cfg_t cfg,
  output logic [3:0]           expected
);
  logic [3:0] cols;

  always_comb begin
    cols[3] = cfg.ocrBits[3] ^ cfg.rcdBits[3] ^ cfg.krcBits[3] ^ cfg.slewBits[3];
    cols[2] = cfg.ocrBits[2] ^ cfg.rcdBits[2] ^ cfg.krcBits[2] ^ cfg.slewBits[2]
              ^ cfg.combineAnd;
    cols[1] = cfg.ocrBits[1] ^ cfg.rcdBits[1] ^ cfg.krcBits[1] ^ cfg.slewBits[1]
              ^ cfg.parallelPair;
    cols[0] = cfg.slewBits[5] ^ cfg.slewBits[4] ^ cfg.slewBits[0];
    expected = cols ^ switch_cfg_pkg::CSUM_ODD_COLS;
  end
endmodule : checksum_calc

// ==== hdl/sense_mux_decode.sv ====
// Purpose: Decode the sense multiplexer code against the selected channel state.
// Assumes: channelOn holds the effective on state of each channel.
// Notes:   Codes above the last channel never route a sense current.
`timescale 1ns/10ps
module sense_mux_decode (
  input  logic [2:0]             muxSel,
  input  logic [5:0]             channelOn,
  output switch_cfg_pkg::sense_t sense
);
  always_comb begin
    sense.route = 6'h00;
    sense.sleep = (muxSel == switch_cfg_pkg::MUX_SLEEP);
    if (muxSel <= switch_cfg_pkg::MUX_LAST && channelOn[muxSel]) begin
      sense.route[muxSel] = 1'b1;
    end
    sense.highZ = (sense.route == 6'h00);
  end
endmodule : sense_mux_decode

// ==== sim/switch_config_register_bank_assertions.sv ====
// Purpose: Port-level assertions for the switch configuration register bank.
// Assumes: Latencies as handed over: read answer and config update one cycle after a frame.
// Notes:   Output-state checks wait for settled inputs because channel state is registered.
`timescale 1ns/10ps
module switch_config_register_bank_checker (
  input logic                   clk_sys,
  input logic                   rst_n,
  input logic                   frameValid,
  input logic [7:0]             frameData,
  input logic                   stdDiagRead,
  input logic [3:0]             inputPin,
  input logic                   limpHome,
  input logic [17:0]            restartCounts,
  input logic [7:0]             respData,
  input logic                   respValid,
  input logic [5:0]             channelDrive,
  input logic [5:0]             faultClear,
  input logic                   softReset,
  input logic                   checksumFail,
  input switch_cfg_pkg::cfg_t   cfgOut,
  input switch_cfg_pkg::sense_t senseOut
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_read_answers: assert property (frameValid && !frameData[7] |=> respValid)
    else $error("read frame without answer");
  a_write_silent: assert property (frameValid && frameData[7] |=> !respValid)
    else $error("write frame answered");
  a_out_update: assert property (
    frameValid && frameData[7:6] == 2'b10 |=> cfgOut.outBits == $past(frameData[5:0]))
    else $error("output bits not taken");
  a_read_keeps_cfg: assert property (frameValid && !frameData[7] |=> $stable(cfgOut))
    else $error("read changed configuration");
  a_wrong_bank_held: assert property (
    frameValid && frameData[7:4] == 4'hC && !cfgOut.bankSwitch |=> $stable(cfgOut.rcdBits))
    else $error("blocked register written");
  a_all_clear: assert property (
    frameValid && frameData == 8'hE1 && !cfgOut.bankSwitch |=> faultClear == 6'h3F)
    else $error("clear all not pulsed");
  a_clear_oneshot: assert property (
    faultClear != 6'h00 && !frameValid |=> faultClear == 6'h00)
    else $error("clear held");
  a_reset_cmd: assert property (
    frameValid && frameData == 8'hE2 && !cfgOut.bankSwitch |=> softReset ##1 !softReset)
    else $error("reset command not a pulse");
  a_sleep_off: assert property (
    cfgOut.muxSel == 3'h7 [*3] |-> channelDrive == 6'h00 && senseOut.sleep && senseOut.highZ)
    else $error("sleep not honoured");
  a_route_match: assert property (
    $stable(cfgOut.muxSel) && senseOut.route != 6'h00
      |-> senseOut.route == (6'h01 << cfgOut.muxSel) && !senseOut.highZ)
    else $error("sense route wrong");
  a_csum_clear: assert property (
    stdDiagRead && !$past(frameValid) |=> !checksumFail)
    else $error("checksum flag not cleared");
  a_limp_or: assert property (
    (limpHome && inputPin[0] && cfgOut.muxSel != 3'h7) [*4] |-> channelDrive[0])
    else $error("limp home not OR");
endmodule : switch_config_register_bank_checker

bind switch_config_register_bank switch_config_register_bank_checker chk (
  .clk_sys       (clk_sys),
  .rst_n         (rst_n),
  .frameValid    (frameValid),
  .frameData     (frameData),
  .stdDiagRead   (stdDiagRead),
  .inputPin      (inputPin),
  .limpHome      (limpHome),
  .restartCounts (restartCounts),
  .respData      (respData),
  .respValid     (respValid),
  .channelDrive  (channelDrive),
  .faultClear    (faultClear),
  .softReset     (softReset),
  .checksumFail  (checksumFail),
  .cfgOut        (cfgOut),
  .senseOut      (senseOut)
);

// ==== sim/spi_master_model.sv ====
// Purpose: Behavioural command master presenting deframed command bytes.
// Assumes: One byte per frame, shown for exactly one clock after an edge.
// Notes:   Released data shows the inverse of the last byte so stale values never match.
`timescale 1ns/10ps
module spi_master_model (
  input  logic       clk_sys,
  output logic       frameValid,
  output logic [7:0] frameData,
  output logic       stdDiagRead
);
  initial begin
    frameValid  = 1'b0;
    frameData   = 8'h00;
    stdDiagRead = 1'b0;
  end

  task automatic send(input logic [7:0] cmd, input int gap = 0);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    frameValid = 1'b1;
    frameData  = cmd;
    @(posedge clk_sys);
    #1;
    frameValid = 1'b0;
    frameData  = ~cmd;
  endtask : send

  task automatic diagRead();
    @(posedge clk_sys);
    #1;
    stdDiagRead = 1'b1;
    @(posedge clk_sys);
    #1;
    stdDiagRead = 1'b0;
  endtask : diagRead
endmodule : spi_master_model

// ==== sim/switch_config_register_bank_tb.sv ====
// Purpose: Self-checking bench for the switch configuration register bank.
// Assumes: Read answers are queued notes matched against each respValid pulse.
// Notes:   Upper bits of read commands are random because the device ignores them.
`timescale 1ns/10ps
module switch_config_register_bank_tb;
  logic                   clk_sys = 1'b0;
  logic                   rst_n;
  logic                   frameValid;
  logic [7:0]             frameData;
  logic                   stdDiagRead;
  logic [3:0]             inputPin;
  logic                   limpHome;
  logic [17:0]            restartCounts;
  logic [7:0]             respData;
  logic                   respValid;
  logic [5:0]             channelDrive;
  logic [5:0]             faultClear;
  logic                   softReset;
  logic                   checksumFail;
  switch_cfg_pkg::cfg_t   cfgOut;
  switch_cfg_pkg::sense_t senseOut;
  logic [7:0]             expQ[$];
  logic [31:0]            seed = 32'h7b1c_de18;
  logic [31:0]            v;
  int                     nErrors = 0;
  int                     nTests = 0;
  logic [3:0] defAddr [11] = '{4'h0, 4'h8, 4'h9, 4'h4, 4'hC, 4'h5, 4'hD, 4'h6, 4'hE, 4'h7, 4'h1};
  logic [7:0] defResp [11] = '{8'h80, 8'h80, 8'h80, 8'hC0, 8'hC0, 8'hD0, 8'hD0, 8'hE2, 8'hE0,
                               8'hF7, 8'h00};

  always #5 clk_sys = ~clk_sys;

  spi_master_model master (
    .clk_sys     (clk_sys),
    .frameValid  (frameValid),
    .frameData   (frameData),
    .stdDiagRead (stdDiagRead)
  );

  switch_config_register_bank DUT (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .frameValid    (frameValid),
    .frameData     (frameData),
    .stdDiagRead   (stdDiagRead),
    .inputPin      (inputPin),
    .limpHome      (limpHome),
    .restartCounts (restartCounts),
    .respData      (respData),
    .respValid     (respValid),
    .channelDrive  (channelDrive),
    .faultClear    (faultClear),
    .softReset     (softReset),
    .checksumFail  (checksumFail),
    .cfgOut        (cfgOut),
    .senseOut      (senseOut)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stopTest();
    if (nErrors == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stopTest

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic rd(input logic [3:0] addr, input logic [7:0] exp);
    logic [31:0] r;
    r = rnd();
    expQ.push_back(exp);
    master.send({1'b0, r[2:0], addr});
  endtask : rd

  always @(posedge clk_sys) begin
    if (rst_n === 1'b1 && respValid === 1'b1) begin
      if (expQ.size() == 0)
        check(respData, 'x);
      else
        check(respData, expQ.pop_front());
    end
  end

  initial begin
    rst_n = 1'b0;
    inputPin = 4'h0;
    limpHome = 1'b0;
    restartCounts = 18'h0_0000;
    repeat (6) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    foreach (defAddr[i]) rd(defAddr[i], defResp[i]);
    // Defaults give all-zero matrix rows, so only the odd columns read one.
    master.send(8'hFF);
    master.send(8'hE5);
    tick(1);
    check(checksumFail, 1'b0);
    master.send(8'hE4, 2);
    tick(1);
    check(checksumFail, 1'b1);
    master.diagRead();
    tick(1);
    check(checksumFail, 1'b0);
    rd(4'h7, 8'hFF);
    master.send(8'hFA);
    master.send(8'hD2);
    check(faultClear, 6'h04);
    master.send(8'hD1);
    rd(4'h9, 8'h84);
    master.send(8'hD9);
    rd(4'hD, 8'hD8);
    master.send(8'hCA);
    rd(4'h4, 8'hC0);
    rd(4'hC, 8'hCA);
    restartCounts = 18'h0_0140;
    tick(2);
    rd(4'h8, 8'h85);
    master.send(8'hF3);
    master.send(8'hC6);
    rd(4'h4, 8'hC6);
    rd(4'hC, 8'hCA);
    master.send(8'hDC);
    rd(4'h5, 8'hDC);
    rd(4'h6, 8'hE0);
    v = rnd();
    master.send({2'b10, v[5:0]});
    rd(4'h0, {2'b10, v[5:0]});
    master.send(8'hE1);
    check(faultClear, 6'h3F);
    master.send(8'h80);
    master.send(8'hE4);
    rd(4'h6, 8'hE4);
    inputPin = v[9:6];
    tick(2);
    rd(4'hE, {4'hE, v[9:6]});
    inputPin = 4'h1;
    tick(3);
    check(channelDrive, 6'h00);
    limpHome = 1'b1;
    tick(4);
    check(channelDrive, 6'h01);
    master.send(8'hE0);
    limpHome = 1'b0;
    tick(3);
    check(channelDrive, 6'h01);
    inputPin = 4'h0;
    master.send(8'h82);
    master.send(8'hF1);
    tick(3);
    check(senseOut, 8'h08);
    check(channelDrive, 6'h06);
    master.send(8'hF6);
    tick(3);
    check(senseOut, 8'h02);
    master.send(8'hF0);
    tick(3);
    check(senseOut, 8'h02);
    master.send(8'hF7);
    tick(3);
    check(senseOut, 8'h03);
    check(channelDrive, 6'h00);
    master.send(8'hE2);
    check(softReset, 1'b1);
    rd(4'h0, 8'h80);
    rd(4'hD, 8'hD0);
    rd(4'h7, 8'hF7);
    for (int i = 0; i < 20 && expQ.size() != 0; i++) @(posedge clk_sys);
    if (expQ.size() != 0) nErrors++;
    stopTest();
  end
endmodule : switch_config_register_bank_tb
